// file: lsg_cfg.svh
`ifndef LSG_CFG_SVH
`define LSG_CFG_SVH

// register offsets
`define LSG_ADDR_GEN_STATUS 8'h0c
`define LSG_ADDR_PIN0_CFG 8'h0d
`define LSG_ADDR_IRQ_STATUS 8'h20
`define LSG_ADDR_IRQ_CLEAR 8'h21
`define LSG_ADDR_IRQ_ENABLE 8'h22

// general status field positions
`define LSG_STAT_LINK_DETECT 0
`define LSG_STAT_DES_CRC 1
`define LSG_STAT_CLK_DETECT 2
`define LSG_STAT_SELFTEST_CRC 3
`define LSG_STAT_LINK_LOST 4

// pin configuration field positions
`define LSG_PIN_MODE_LSB 0
`define LSG_PIN_MODE_MSB 2
`define LSG_PIN_OUT_VAL 3
`define LSG_PIN_REV_LSB 4
`define LSG_PIN_REV_MSB 7

// interrupt field positions, one bit per port in each pair
`define LSG_IRQ_LOST_LSB 0
`define LSG_IRQ_DES_LSB 2
`define LSG_IRQ_SELFTEST_LSB 4
`define LSG_IRQ_CLK_LOSS 6
`define LSG_IRQ_WIDTH 7

// reset values
`define LSG_PIN_MODE_RST 3'h0
`define LSG_PIN_OUT_VAL_RST 1'h0
`define LSG_IRQ_EN_RST 7'h00
`define LSG_IRQ_STAT_RST 7'h00
`define LSG_PIN_DRIVE_OUT_RST 1'h0
`define LSG_PIN_OE_N_RST 1'h1
`define LSG_RDATA_RST 8'h00

// synchroniser depth
`define LSG_SYNC_STAGES 2

`endif

// file: lsg_pkg.sv
package lsg_pkg;

  typedef enum logic [2:0] {
    LSG_MODE_LOCAL_OUT = 3'h1,
    LSG_MODE_LOCAL_IN = 3'h3,
    LSG_MODE_REMOTE_HOLD = 3'h5,
    LSG_MODE_REMOTE_DEFAULT = 3'h7
  } lsg_pin_mode_t;

  typedef struct packed {
    logic out_val;
    logic [2:0] mode;
  } lsg_pin_cfg_t;

  typedef struct packed {
    logic link_lost;
    logic selftest_crc;
    logic des_crc;
  } lsg_port_status_t;

  typedef struct packed {
    logic des_crc;
    logic selftest_crc;
    logic selftest_restart;
  } lsg_port_evt_t;

  typedef struct packed {
    logic out;
    logic oe_n;
  } lsg_pin_drive_t;

endpackage

// file: lsg_remote_model.sv
`timescale 1ns/1ps
module lsg_remote_model (
  input wire logic sys_clk_i,
  input wire logic [1:0] up_i,
  input wire logic [1:0] val_i,
  output logic [1:0] link_detect_o,
  output logic [1:0] remote_pin_o
);
  logic [1:0] junk = 2'h0;
  logic [1:0] last = 2'h0;
  logic [1:0][2:0] gone = '0;
  always @(posedge sys_clk_i) begin
    junk <= ~junk;
    for (int p = 0; p < 2; p++) begin
      if (up_i[p]) begin
        last[p] <= val_i[p];
        gone[p] <= 3'h0;
      end else if (gone[p] != 3'h7) begin
        gone[p] <= gone[p] + 3'h1;
      end
    end
  end
  // after a loss the receiver keeps its last frame for four cycles, then the value is meaningless
  assign link_detect_o = up_i;
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      remote_pin_o[p] = up_i[p] ? val_i[p] : ((gone[p] < 3'h4) ? last[p] : junk[p]);
    end
  end
endmodule

// file: lsg_sync.sv
`timescale 1ns/1ps
module lsg_sync #(
  parameter int WIDTH = 1,
  parameter int STAGES = 2
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  typedef struct packed {
    logic [STAGES-1:0][WIDTH-1:0] stage;
  } lsg_sync_state_t;

  lsg_sync_state_t st;
  lsg_sync_state_t next_st;

  if (WIDTH < 1 || STAGES < 2) begin : g_bad
    $error("lsg_sync needs WIDTH >= 1 and STAGES >= 2");
  end

  // stage 0 is read only by stage 1
  always_comb begin
    next_st = st;
    next_st.stage[0] = async_i;
    for (int i = 1; i < STAGES; i++) begin
      next_st.stage[i] = st.stage[i-1];
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_o = st.stage[STAGES-1];
endmodule

// file: lsg_top.sv
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "lsg_cfg.svh"
module lsg_top
  import lsg_pkg::*;
#(
  parameter logic [3:0] REVISION_ID = 4'h1 // arbitrary value
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic second_link_select_i,
  input wire logic crc_error_reset_i,
  input wire logic [1:0] link_detect_i,
  input wire logic clk_detect_i,
  input wire lsg_port_evt_t [1:0] port_evt_i,
  input wire logic [1:0] remote_pin_i,
  input wire logic pin0_i,
  output logic pin0_o,
  output logic pin0_oe_n_o,
  input wire logic secondary_port_pin0_i,
  output logic secondary_port_pin0_o,
  output logic secondary_port_pin0_oe_n_o,
  output logic [1:0] pin_in_value_o,
  output logic irq_o
);
  typedef struct packed {
    lsg_pin_cfg_t [1:0] pin_cfg;
    lsg_port_status_t [1:0] stat;
    logic [1:0] link_prev;
    logic clk_prev;
    logic [1:0] held;
    lsg_pin_drive_t [1:0] drive;
    logic [1:0] pin_in_val;
    logic [`LSG_IRQ_WIDTH-1:0] irq_stat;
    logic [`LSG_IRQ_WIDTH-1:0] irq_en;
    logic irq;
    logic [7:0] rdata;
  } lsg_state_t;

  lsg_state_t st;
  lsg_state_t next_st;

  logic [1:0] link_sync;
  logic clk_sync;
  logic [1:0] pin_sync;

  lsg_sync #(
    .WIDTH(5),
    .STAGES(`LSG_SYNC_STAGES)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .async_i({secondary_port_pin0_i, pin0_i, clk_detect_i, link_detect_i}),
    .sync_o({pin_sync, clk_sync, link_sync})
  );

  // the field map must fit the 8-bit register bus and the declared types
  if ($bits(REVISION_ID) != (`LSG_PIN_REV_MSB - `LSG_PIN_REV_LSB + 1)) begin : g_bad_rev
    $error("lsg_top revision field width does not match REVISION_ID");
  end
  if ((`LSG_PIN_MODE_MSB - `LSG_PIN_MODE_LSB + 1) != $bits(lsg_pin_mode_t)) begin : g_bad_mode
    $error("lsg_top mode field width does not match the mode type");
  end
  if (`LSG_PIN_OUT_VAL != `LSG_PIN_MODE_MSB + 1 || `LSG_PIN_REV_LSB != `LSG_PIN_OUT_VAL + 1) begin : g_bad_cfg
    $error("lsg_top pin configuration fields overlap or leave gaps");
  end
  if (`LSG_IRQ_WIDTH > 8 || `LSG_IRQ_CLK_LOSS >= `LSG_IRQ_WIDTH) begin : g_bad_irq
    $error("lsg_top interrupt bits do not fit the register");
  end
  if (`LSG_IRQ_LOST_LSB + 2 > `LSG_IRQ_DES_LSB || `LSG_IRQ_DES_LSB + 2 > `LSG_IRQ_SELFTEST_LSB
      || `LSG_IRQ_SELFTEST_LSB + 2 > `LSG_IRQ_CLK_LOSS) begin : g_bad_irq_map
    $error("lsg_top interrupt fields overlap");
  end
  // the five status flags must sit on distinct bits below the reserved field
  if (((1 << `LSG_STAT_LINK_DETECT) | (1 << `LSG_STAT_DES_CRC) | (1 << `LSG_STAT_CLK_DETECT)
      | (1 << `LSG_STAT_SELFTEST_CRC) | (1 << `LSG_STAT_LINK_LOST)) != 32'h1f) begin : g_bad_stat
    $error("lsg_top status flags overlap or reach the reserved bits");
  end
  if (`LSG_ADDR_GEN_STATUS == `LSG_ADDR_PIN0_CFG || `LSG_ADDR_IRQ_STATUS == `LSG_ADDR_IRQ_CLEAR
      || `LSG_ADDR_IRQ_CLEAR == `LSG_ADDR_IRQ_ENABLE || `LSG_ADDR_IRQ_STATUS == `LSG_ADDR_IRQ_ENABLE) begin : g_bad_addr
    $error("lsg_top register addresses collide");
  end
  if (`LSG_SYNC_STAGES < 2) begin : g_bad_sync
    $error("lsg_top needs at least two synchroniser stages");
  end

  // drive decision for one pin from its config and link state
  function automatic lsg_pin_drive_t pin_drive(
    input lsg_pin_cfg_t cfg,
    input logic link_up,
    input logic remote_val,
    input logic held_val
  );
    lsg_pin_drive_t d;
    d.out = 1'b0;
    d.oe_n = 1'b1;
    if (cfg.mode[0]) begin
      case (cfg.mode)
        LSG_MODE_LOCAL_OUT: begin
          d.out = cfg.out_val;
          d.oe_n = 1'b0;
        end
        LSG_MODE_LOCAL_IN: begin
          d.oe_n = 1'b1;
        end
        LSG_MODE_REMOTE_HOLD: begin
          d.out = link_up ? remote_val : held_val;
          d.oe_n = 1'b0;
        end
        LSG_MODE_REMOTE_DEFAULT: begin
          d.out = link_up ? remote_val : cfg.out_val;
          d.oe_n = 1'b0;
        end
        default: begin
          d.oe_n = 1'b1;
        end
      endcase
    end else begin
      d.oe_n = 1'b1;
    end
    return d;
  endfunction

  // general status image of the selected port
  function automatic logic [7:0] status_image(
    input lsg_port_status_t s,
    input logic link_up,
    input logic clk_ok
  );
    logic [7:0] v;
    v = 8'h00;
    v[`LSG_STAT_LINK_LOST] = s.link_lost;
    v[`LSG_STAT_SELFTEST_CRC] = s.selftest_crc;
    v[`LSG_STAT_CLK_DETECT] = clk_ok;
    v[`LSG_STAT_DES_CRC] = s.des_crc;
    v[`LSG_STAT_LINK_DETECT] = link_up;
    return v;
  endfunction

  // pin configuration image: revision on top, never stored upper bits
  function automatic logic [7:0] cfg_image(
    input lsg_pin_cfg_t c,
    input logic [3:0] rev
  );
    logic [7:0] v;
    v = 8'h00;
    v[`LSG_PIN_REV_MSB:`LSG_PIN_REV_LSB] = rev;
    v[`LSG_PIN_OUT_VAL] = c.out_val;
    v[`LSG_PIN_MODE_MSB:`LSG_PIN_MODE_LSB] = c.mode;
    return v;
  endfunction

  always_comb begin
    logic sel;
    logic [1:0] lost_evt;
    logic [1:0] des_evt;
    logic [1:0] st_evt;
    logic clk_loss_evt;
    lsg_pin_cfg_t cur_cfg;
    sel = second_link_select_i;
    lost_evt = 2'h0;
    des_evt = 2'h0;
    st_evt = 2'h0;
    clk_loss_evt = st.clk_prev & ~clk_sync;
    cur_cfg = st.pin_cfg[sel];
    next_st = st;
    next_st.clk_prev = clk_sync;

    for (int p = 0; p < 2; p++) begin
      lost_evt[p] = st.link_prev[p] & ~link_sync[p];
      des_evt[p] = port_evt_i[p].des_crc;
      st_evt[p] = port_evt_i[p].selftest_crc;
      next_st.link_prev[p] = link_sync[p];

      // link lost: only the crc error reset clears it, a new loss wins
      if (crc_error_reset_i) begin
        next_st.stat[p].link_lost = 1'b0;
      end
      if (lost_evt[p]) begin
        next_st.stat[p].link_lost = 1'b1;
      end

      if (crc_error_reset_i || lost_evt[p] || port_evt_i[p].selftest_restart) begin
        next_st.stat[p].selftest_crc = 1'b0;
      end
      if (st_evt[p]) begin
        next_st.stat[p].selftest_crc = 1'b1;
      end

      if (crc_error_reset_i || lost_evt[p]) begin
        next_st.stat[p].des_crc = 1'b0;
      end
      if (des_evt[p]) begin
        next_st.stat[p].des_crc = 1'b1;
      end

      // remember the last value received while the link was up; the synchronised
      // detect lags the pin by two edges, so the far side must keep its last frame
      // that long or the held value picks up a dying link
      if (link_sync[p]) begin
        next_st.held[p] = remote_pin_i[p];
      end

      next_st.drive[p] = pin_drive(st.pin_cfg[p], link_sync[p], remote_pin_i[p], st.held[p]);
      next_st.pin_in_val[p] = pin_sync[p];
    end

    if (wr_i) begin
      case (addr_i)
        `LSG_ADDR_PIN0_CFG: begin
          // upper bits carry the revision and are not stored
          next_st.pin_cfg[sel].out_val = wdata_i[`LSG_PIN_OUT_VAL];
          next_st.pin_cfg[sel].mode = wdata_i[`LSG_PIN_MODE_MSB:`LSG_PIN_MODE_LSB];
        end
        `LSG_ADDR_IRQ_CLEAR: begin
          next_st.irq_stat = st.irq_stat & ~wdata_i[`LSG_IRQ_WIDTH-1:0];
        end
        `LSG_ADDR_IRQ_ENABLE: begin
          next_st.irq_en = wdata_i[`LSG_IRQ_WIDTH-1:0];
        end
        `LSG_ADDR_GEN_STATUS, `LSG_ADDR_IRQ_STATUS: begin
          // read-only registers: the write is dropped
          next_st.irq_en = st.irq_en;
        end
        default: begin
          next_st.irq_en = st.irq_en;
        end
      endcase
    end

    // events set after the clear so a coincident event is kept
    next_st.irq_stat[`LSG_IRQ_LOST_LSB +: 2] = next_st.irq_stat[`LSG_IRQ_LOST_LSB +: 2] | lost_evt;
    next_st.irq_stat[`LSG_IRQ_DES_LSB +: 2] = next_st.irq_stat[`LSG_IRQ_DES_LSB +: 2] | des_evt;
    next_st.irq_stat[`LSG_IRQ_SELFTEST_LSB +: 2] = next_st.irq_stat[`LSG_IRQ_SELFTEST_LSB +: 2] | st_evt;
    if (clk_loss_evt) begin
      next_st.irq_stat[`LSG_IRQ_CLK_LOSS] = 1'b1;
    end
    next_st.irq = |(next_st.irq_stat & next_st.irq_en);

    next_st.rdata = 8'h00;
    if (rd_i) begin
      case (addr_i)
        `LSG_ADDR_GEN_STATUS: begin
          next_st.rdata = status_image(st.stat[sel], link_sync[sel], clk_sync);
        end
        `LSG_ADDR_PIN0_CFG: begin
          next_st.rdata = cfg_image(cur_cfg, REVISION_ID);
        end
        `LSG_ADDR_IRQ_STATUS: begin
          next_st.rdata[`LSG_IRQ_WIDTH-1:0] = st.irq_stat;
        end
        `LSG_ADDR_IRQ_CLEAR: begin
          // write-only: reads return zero
          next_st.rdata = 8'h00;
        end
        `LSG_ADDR_IRQ_ENABLE: begin
          next_st.rdata[`LSG_IRQ_WIDTH-1:0] = st.irq_en;
        end
        default: begin
          next_st.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st <= '0;
      st.pin_cfg[0].mode <= `LSG_PIN_MODE_RST;
      st.pin_cfg[1].mode <= `LSG_PIN_MODE_RST;
      st.pin_cfg[0].out_val <= `LSG_PIN_OUT_VAL_RST;
      st.pin_cfg[1].out_val <= `LSG_PIN_OUT_VAL_RST;
      st.drive[0].out <= `LSG_PIN_DRIVE_OUT_RST;
      st.drive[1].out <= `LSG_PIN_DRIVE_OUT_RST;
      st.drive[0].oe_n <= `LSG_PIN_OE_N_RST;
      st.drive[1].oe_n <= `LSG_PIN_OE_N_RST;
      st.irq_stat <= `LSG_IRQ_STAT_RST;
      st.irq <= 1'h0;
      st.rdata <= `LSG_RDATA_RST;
      st.irq_en <= `LSG_IRQ_EN_RST;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o = st.rdata;
  assign pin0_o = st.drive[0].out;
  assign pin0_oe_n_o = st.drive[0].oe_n;
  assign secondary_port_pin0_o = st.drive[1].out;
  assign secondary_port_pin0_oe_n_o = st.drive[1].oe_n;
  assign pin_in_value_o = st.pin_in_val;
  assign irq_o = st.irq;
endmodule

// file: lsg_top_asserts.sv
`timescale 1ns/1ps
module lsg_top_asserts
  import lsg_pkg::*;
#(
  parameter logic [3:0] REVISION_ID = 4'h1
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic second_link_select_i,
  input wire logic [1:0] link_detect_i,
  input wire logic [1:0] remote_pin_i,
  input wire logic pin0_o,
  input wire logic pin0_oe_n_o,
  input wire logic secondary_port_pin0_oe_n_o
);
  lsg_pin_cfg_t [1:0] cfg;
  logic [2:0] lk;
  logic ld_q;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  // shadow of both port configs and a count of cycles the port0 link stood still
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg <= '0;
      lk <= 3'h0;
      ld_q <= 1'b0;
    end else begin
      if (wr_i && addr_i == 8'h0d) begin
        cfg[second_link_select_i] <= wdata_i[3:0];
      end
      ld_q <= link_detect_i[0];
      lk <= (link_detect_i[0] != ld_q) ? 3'h0 : ((lk == 3'h7) ? lk : lk + 3'h1);
    end
  end
  a_stat_reserved: assert property (rd_i && addr_i == 8'h0c |=> rdata_o[7:5] == 3'h0)
    else $error("status reserved bits set");
  a_rev_field: assert property (rd_i && addr_i == 8'h0d |=> rdata_o[7:4] == REVISION_ID)
    else $error("revision field wrong");
  a_pin_hiz: assert property (!cfg[0].mode[0] || cfg[0].mode == 3'h3 |=> pin0_oe_n_o)
    else $error("pin driven while released");
  a_local_drive: assert property (cfg[0].mode == 3'h1 |=> !pin0_oe_n_o && pin0_o == $past(cfg[0].out_val))
    else $error("local output wrong");
  a_remote_up: assert property (cfg[0].mode[2] && cfg[0].mode[0] && link_detect_i[0] && lk >= 3'h4
    |=> !pin0_oe_n_o && pin0_o == $past(remote_pin_i[0]))
    else $error("remote value not driven");
  a_remote_hold: assert property (cfg[0].mode == 3'h5 && $past(cfg[0].mode) == 3'h5 && !link_detect_i[0] && lk >= 3'h4
    |=> !pin0_oe_n_o && $stable(pin0_o))
    else $error("held value moved");
  a_remote_dflt: assert property (cfg[0].mode == 3'h7 && !link_detect_i[0] && lk >= 3'h4
    |=> !pin0_oe_n_o && pin0_o == $past(cfg[0].out_val))
    else $error("default value not driven");
  a_second_pin: assert property (!cfg[1].mode[0] |=> secondary_port_pin0_oe_n_o)
    else $error("second pin driven while released");
endmodule

bind lsg_top lsg_top_asserts #(.REVISION_ID(REVISION_ID)) chk_u (.*);

// file: lsg_top_tb.sv
`timescale 1ns/1ps
module lsg_top_tb
  import lsg_pkg::*;
();
  localparam logic [3:0] REV = 4'h9; // arbitrary value
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic second_link_select_i = 1'b0;
  logic crc_error_reset_i = 1'b0;
  logic [1:0] link_detect_i;
  logic clk_detect_i = 1'b0;
  lsg_port_evt_t [1:0] port_evt_i = '0;
  logic [1:0] remote_pin_i;
  logic pin0_i = 1'b0;
  logic pin0_o;
  logic pin0_oe_n_o;
  logic secondary_port_pin0_i = 1'b0;
  logic secondary_port_pin0_o;
  logic secondary_port_pin0_oe_n_o;
  logic [1:0] pin_in_value_o;
  logic irq_o;
  logic [1:0] up = 2'h0;
  logic [1:0] val = 2'h0;
  logic [2:0] m;
  int errors = 0;
  int samples_checked = 0;
  always #25 sys_clk_i = ~sys_clk_i;
  lsg_top #(.REVISION_ID(REV)) dut_u (.*);
  lsg_remote_model far_u (.sys_clk_i(sys_clk_i), .up_i(up), .val_i(val), .link_detect_o(link_detect_i),
    .remote_pin_o(remote_pin_i));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h saw %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 chk($sformatf("reg %h", a), rdata_o, e);
  endtask
  task automatic pulse(input int p, input lsg_port_evt_t v);
    @(posedge sys_clk_i);
    port_evt_i[p] <= v;
    @(posedge sys_clk_i);
    port_evt_i[p] <= '0;
    #1;
  endtask
  task automatic crc_clear();
    @(posedge sys_clk_i);
    crc_error_reset_i <= 1'b1;
    @(posedge sys_clk_i);
    crc_error_reset_i <= 1'b0;
  endtask
  task automatic close_out();
    if (errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    cyc(3);
    reset_n_i <= 1'b1;
    rd(8'h0c, 8'h00);
    rd(8'h0d, {REV, 4'h0});
    rd(8'h22, 8'h00);
    rd(8'h31, 8'h00);
    wr(8'h0d, 8'h59);
    rd(8'h0d, {REV, 4'h9});
    cyc(1);
    up <= 2'h3;
    clk_detect_i <= 1'b1;
    cyc(5);
    rd(8'h0c, 8'h05);
    wr(8'h22, 8'h04);
    pulse(0, 3'b100);
    chk("irq", irq_o, 8'h01);
    rd(8'h0c, 8'h07);
    rd(8'h20, 8'h04);
    wr(8'h21, 8'h04);
    #1 chk("irq", irq_o, 8'h00);
    wr(8'h22, 8'h00);
    pulse(0, 3'b010);
    chk("irq", irq_o, 8'h00);
    rd(8'h0c, 8'h0f);
    pulse(0, 3'b001);
    rd(8'h0c, 8'h07);
    pulse(0, 3'b010);
    crc_clear();
    rd(8'h0c, 8'h05);
    pulse(1, 3'b100);
    cyc(1);
    second_link_select_i <= 1'b1;
    rd(8'h0c, 8'h07);
    cyc(1);
    second_link_select_i <= 1'b0;
    rd(8'h0c, 8'h05);
    pulse(0, 3'b110);
    cyc(1);
    up <= 2'h2;
    cyc(5);
    rd(8'h0c, 8'h14);
    cyc(1);
    up <= 2'h3;
    cyc(5);
    rd(8'h0c, 8'h15);
    crc_clear();
    rd(8'h0c, 8'h05);
    rd(8'h20, 8'h1d);
    rd(8'h21, 8'h00);
    wr(8'h22, 8'h01);
    rd(8'h22, 8'h01);
    cyc(1);
    #1 chk("irq", irq_o, 8'h01);
    wr(8'h21, 8'h7f);
    cyc(1);
    #1 chk("irq", irq_o, 8'h00);
    cyc(1);
    clk_detect_i <= 1'b0;
    cyc(5);
    rd(8'h0c, 8'h01);
    rd(8'h20, 8'h40);
    for (int i = 0; i < 8; i++) begin
      m = 3'(i);
      wr(8'h0d, {5'h01, m});
      cyc(3);
      #1 chk("pin0 oe", pin0_oe_n_o, {7'h0, !m[0] || m == 3'h3});
      if (m[0] && m != 3'h3) begin
        chk("pin0", pin0_o, {7'h0, m == 3'h1});
      end
    end
    wr(8'h0d, 8'h05);
    val <= 2'h1;
    cyc(3);
    up <= 2'h2;
    cyc(6);
    #1 chk("pin0 hold", pin0_o, 8'h01);
    wr(8'h0d, 8'h07);
    cyc(3);
    #1 chk("pin0 dflt", pin0_o, 8'h00);
    wr(8'h0d, 8'h03);
    up <= 2'h3;
    pin0_i <= 1'b1;
    cyc(4);
    #1 chk("pin in", pin_in_value_o, 8'h01);
    cyc(1);
    second_link_select_i <= 1'b1;
    wr(8'h0d, 8'h09);
    cyc(3);
    #1 chk("pin1", {secondary_port_pin0_oe_n_o, secondary_port_pin0_o}, 8'h01);
    chk("pin0 oe", pin0_oe_n_o, 8'h01);
    close_out();
  end
endmodule
